// ===== logic/uda_arb.sv
/*
 Grant logic for the four DMA masters toward the system bus.
 Assumes requests arrive on clk_i and are held until granted.
*/
module uda_arb (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             en_i,
    input  wire logic             mode_i,
    input  wire logic [7:0]       prio_i,
    input  wire logic [3:0]       req_i,
    output logic      [3:0]       gnt_o
);
    import uda_pkg::*;

    logic [1:0] last_q;
    logic [1:0] last_d;
    logic [3:0] gnt_c;
    logic [3:0] gnt_q;

    // ==========================================================================
    // Grant choice
    always_comb begin
        logic [2:0] best;
        logic [1:0] idx;
        gnt_c = 4'h0;
        best  = 3'h4;
        idx   = 2'h0;
        if (en_i) begin
            if (mode_i) begin
                for (int i = 0; i < NMST; i++) begin
                    if (req_i[i] && {1'b0, prio_i[2*i +: 2]} < best) begin
                        best = {1'b0, prio_i[2*i +: 2]};
                        idx  = 2'(i);
                    end
                end
                if (best != 3'h4) gnt_c[idx] = 1'b1;
            end else begin
                // Search ends just past the last winner and the last match wins, so the last winner ranks lowest
                for (int k = NMST; k >= 1; k--) begin
                    idx = 2'(last_q + 2'(k));
                    if (req_i[idx]) begin
                        gnt_c    = 4'h0;
                        gnt_c[idx] = 1'b1;
                    end
                end
            end
        end
    end

    always_comb begin
        last_d = last_q;
        for (int i = 0; i < NMST; i++) begin
            if (gnt_c[i]) last_d = 2'(i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            last_q <= 2'h3;
            gnt_q  <= 4'h0;
        end else begin
            last_q <= last_d;
            gnt_q  <= gnt_c;
        end
    end

    assign gnt_o = gnt_q;

    chk_grant_needs_en: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !en_i |=> gnt_o == 4'h0) else $error("grant while arbiter disabled");
    chk_grant_onehot: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $onehot0(gnt_o)) else $error("more than one grant");
endmodule : uda_arb

// ===== logic/uda_pkg.sv
/*
 Package for the USB DMA arbiter and address register block.
 Holds register offsets, field positions and reset values; assumes an APB slave with 32-bit data.
*/
package uda_pkg;
    // ==========================================================================
    // Register offsets
    localparam logic [7:0] OFS_ARB      = 8'h3c;
    localparam logic [7:0] OFS_WR_START = 8'h40;
    localparam logic [7:0] OFS_WR_END   = 8'h44;
    localparam logic [7:0] OFS_WR_CUR   = 8'h48;
    localparam logic [7:0] OFS_WR_BUS   = 8'h4c;
    localparam logic [7:0] OFS_RD_START = 8'h50;
    localparam logic [7:0] OFS_RDREQ    = 8'h14;
    localparam logic [7:0] OFS_RDVAL    = 8'h18;
    localparam logic [7:0] OFS_XFER_CTL = 8'h08;
    // ==========================================================================
    // Arbiter setting fields
    localparam int ARB_EN_BIT   = 31;
    localparam int ARB_MODE_BIT = 28;
    localparam int PRIO_W1_LSB  = 12;
    localparam int PRIO_W0_LSB  = 8;
    localparam int PRIO_R1_LSB  = 4;
    localparam int PRIO_R0_LSB  = 0;
    localparam logic [1:0] PRIO_W1_RST = 2'h3;
    localparam logic [1:0] PRIO_W0_RST = 2'h2;
    localparam logic [1:0] PRIO_R1_RST = 2'h1;
    localparam logic [1:0] PRIO_R0_RST = 2'h0;
    localparam logic       ARB_EN_RST  = 1'h1;
    localparam logic       ARB_MODE_RST = 1'h0;
    // ==========================================================================
    // Address and read request
    localparam logic [31:0] ADDR_RST     = 32'h0fffffff;
    localparam logic [31:0] CUR_RST      = 32'h00000000;
    localparam int          RDREQ_BIT    = 31;
    localparam int          RDCLR_BIT    = 30;
    localparam int          RDSEL_LSB    = 2;
    localparam logic [5:0]  RDSEL_WR_CUR = 6'h12;
    localparam int          XFER_EN_BIT  = 0;
    localparam logic [31:0] WORD_STEP    = 32'h00000004;
    localparam logic [31:0] WORD_MASK    = 32'hfffffffc;
    localparam int          NMST         = 4;
    localparam logic [1:0]  MST_R0       = 2'h0;
    localparam logic [1:0]  MST_W0       = 2'h2;
endpackage : uda_pkg

// ===== logic/uda_top.sv
/*
 USB DMA arbiter settings, write/read transfer address registers and progress counters.
 Assumes an APB master on clk_i (50 MHz) and DMA datapath strobes from the same clock.
*/
// Chosen here: the APB register port.
// Contract
// - Mode and priority writes ignored unless enable was cleared beforehand.
// - Enable at bit 31, resets to one; zero blocks all DMA bus access.
// - Mode bit 28: zero round-robin, one fixed priority from fields.
// - Four two-bit priority fields at 13:12, 9:8, 5:4, 1:0; zero highest.
// - Priorities reset to 3, 2, 1, 0 for W1, W0, R1, R0.
// - Enable write refused when any two priority fields are equal; checks the fields held before the write, not ones written with it.
// - Second channels' fields stored, drive nothing, but join the distinctness check.
// - Write current address unreadable directly; only through indirect read path.
// - Write current address resets zero, advances per endpoint-to-buffer move.
// - Write bus address advances per bus delivery, recorded word aligned.
// - Write start, end, bus address and read start reset to 0x0fffffff.
// - Read request with selector 0x48 fetches current address, self-clears, flags done.
// - Write transfer enable set after addresses; hardware clears it when finished.
module uda_top (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        wr_ep_move_i,
    input  wire logic        wr_bus_move_i,
    input  wire logic [31:0] wr_bus_addr_i,
    input  wire logic        wr_xfer_done_i,
    input  wire logic [3:0]  dma_req_i,
    output logic      [3:0]  dma_gnt_o,
    output logic             write_xfer_enable_o,
    output logic             read_done_flag_o
);
    import uda_pkg::*;

    // ==========================================================================
    // State
    logic        arb_en_q, arb_en_d;
    logic        arb_mode_q, arb_mode_d;
    logic [1:0]  prio_w1_q, prio_w1_d, prio_w0_q, prio_w0_d;
    logic [1:0]  prio_r1_q, prio_r1_d, prio_r0_q, prio_r0_d;
    logic [31:0] wr_start_q, wr_start_d, wr_end_q, wr_end_d;
    logic [31:0] wr_cur_q, wr_cur_d, wr_bus_q, wr_bus_d;
    logic [31:0] rd_start_q, rd_start_d;
    logic        rdreq_q, rdreq_d;
    logic [5:0]  rdsel_q, rdsel_d;
    logic [31:0] rdval_q, rdval_d;
    logic        rddone_q, rddone_d;
    logic        xfer_en_q, xfer_en_d;
    logic [31:0] prdata_q, prdata_d;
    logic        perr_q, perr_d;
    logic        wr_acc, rd_acc, acc_end;

    function automatic logic prio_distinct(input logic [1:0] a, input logic [1:0] b,
                                           input logic [1:0] c, input logic [1:0] d);
        prio_distinct = (a != b) && (a != c) && (a != d) && (b != c) && (b != d) && (c != d);
    endfunction : prio_distinct

    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            OFS_ARB, OFS_WR_START, OFS_WR_END, OFS_WR_CUR, OFS_WR_BUS,
            OFS_RD_START, OFS_RDREQ, OFS_RDVAL, OFS_XFER_CTL: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    // ==========================================================================
    // Bus handshake: setup then a single access cycle, always ready
    assign acc_end = psel_i && penable_i;
    assign wr_acc  = acc_end && pwrite_i;
    assign rd_acc  = psel_i && !penable_i && !pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = perr_q;
    assign prdata_o  = prdata_q;

    // ==========================================================================
    // Arbiter setting
    always_comb begin
        arb_en_d   = arb_en_q;
        arb_mode_d = arb_mode_q;
        prio_w1_d  = prio_w1_q;
        prio_w0_d  = prio_w0_q;
        prio_r1_d  = prio_r1_q;
        prio_r0_d  = prio_r0_q;
        if (wr_acc && paddr_i == OFS_ARB) begin
            // Fields only move while the arbiter already stands disabled
            if (!arb_en_q) begin
                arb_mode_d = pwdata_i[ARB_MODE_BIT];
                prio_w1_d  = pwdata_i[PRIO_W1_LSB +: 2];
                prio_w0_d  = pwdata_i[PRIO_W0_LSB +: 2];
                prio_r1_d  = pwdata_i[PRIO_R1_LSB +: 2];
                prio_r0_d  = pwdata_i[PRIO_R0_LSB +: 2];
            end
            if (!pwdata_i[ARB_EN_BIT]) begin
                arb_en_d = 1'b0;
            end else if (prio_distinct(prio_w1_q, prio_w0_q, prio_r1_q, prio_r0_q)) begin
                arb_en_d = 1'b1;
            end
        end
    end

    // ==========================================================================
    // Address registers and progress counters
    always_comb begin
        wr_start_d = wr_start_q;
        wr_end_d   = wr_end_q;
        rd_start_d = rd_start_q;
        wr_cur_d   = wr_cur_q;
        wr_bus_d   = wr_bus_q;
        xfer_en_d  = xfer_en_q;
        if (wr_acc) begin
            case (paddr_i)
                OFS_WR_START: wr_start_d = pwdata_i;
                OFS_WR_END:   wr_end_d   = pwdata_i;
                OFS_RD_START: rd_start_d = pwdata_i;
                OFS_XFER_CTL: if (pwdata_i[XFER_EN_BIT]) begin
                    xfer_en_d = 1'b1;
                    wr_cur_d  = wr_start_q;
                end
                default: ;
            endcase
        end
        if (xfer_en_q && wr_ep_move_i) begin
            wr_cur_d = wr_cur_q + WORD_STEP;
        end
        if (xfer_en_q && wr_bus_move_i) begin
            wr_bus_d = wr_bus_addr_i & WORD_MASK;
        end
        // Hardware finish wins over a software set in the same cycle
        if (wr_xfer_done_i) begin
            xfer_en_d = 1'b0;
        end
    end

    // ==========================================================================
    // Indirect read of the current address
    always_comb begin
        rdreq_d  = rdreq_q;
        rdsel_d  = rdsel_q;
        rdval_d  = rdval_q;
        rddone_d = rddone_q;
        if (wr_acc && paddr_i == OFS_RDREQ) begin
            rdsel_d = pwdata_i[RDSEL_LSB +: 6];
            if (pwdata_i[RDREQ_BIT]) rdreq_d = 1'b1;
            if (pwdata_i[RDCLR_BIT]) rdreq_d = 1'b0;
            if (pwdata_i[RDREQ_BIT]) rddone_d = 1'b0;
        end
        if (rdreq_q) begin
            rdval_d  = (rdsel_q == RDSEL_WR_CUR) ? wr_cur_q : CUR_RST;
            rdreq_d  = 1'b0;
            rddone_d = 1'b1;
        end
    end

    // ==========================================================================
    // Read data mux, captured in the setup cycle
    always_comb begin
        prdata_d = prdata_q;
        perr_d   = 1'b0;
        if (rd_acc) begin
            case (paddr_i)
                OFS_ARB:      prdata_d = {arb_en_q, 2'h0, arb_mode_q, 14'h0, prio_w1_q, 2'h0,
                                          prio_w0_q, 2'h0, prio_r1_q, 2'h0, prio_r0_q};
                OFS_WR_START: prdata_d = wr_start_q;
                OFS_WR_END:   prdata_d = wr_end_q;
                OFS_WR_CUR:   prdata_d = 32'h00000000;
                OFS_WR_BUS:   prdata_d = wr_bus_q;
                OFS_RD_START: prdata_d = rd_start_q;
                OFS_RDREQ:    prdata_d = {rdreq_q, 23'h0, rdsel_q, 2'h0};
                OFS_RDVAL:    prdata_d = rdval_q;
                OFS_XFER_CTL: prdata_d = {31'h0, xfer_en_q};
                default:      prdata_d = 32'h00000000;
            endcase
        end
        // Decoded in setup so the error stands through the access phase
        if (psel_i && !penable_i) begin
            perr_d = !addr_mapped(paddr_i);
        end
    end

    // ==========================================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            arb_en_q   <= ARB_EN_RST;
            arb_mode_q <= ARB_MODE_RST;
            prio_w1_q  <= PRIO_W1_RST;
            prio_w0_q  <= PRIO_W0_RST;
            prio_r1_q  <= PRIO_R1_RST;
            prio_r0_q  <= PRIO_R0_RST;
            wr_start_q <= ADDR_RST;
            wr_end_q   <= ADDR_RST;
            wr_bus_q   <= ADDR_RST;
            rd_start_q <= ADDR_RST;
            wr_cur_q   <= CUR_RST;
            rdreq_q    <= 1'b0;
            rdsel_q    <= 6'h00;
            rdval_q    <= CUR_RST;
            rddone_q   <= 1'b0;
            xfer_en_q  <= 1'b0;
            prdata_q   <= 32'h00000000;
            perr_q     <= 1'b0;
        end else begin
            arb_en_q   <= arb_en_d;
            arb_mode_q <= arb_mode_d;
            prio_w1_q  <= prio_w1_d;
            prio_w0_q  <= prio_w0_d;
            prio_r1_q  <= prio_r1_d;
            prio_r0_q  <= prio_r0_d;
            wr_start_q <= wr_start_d;
            wr_end_q   <= wr_end_d;
            wr_bus_q   <= wr_bus_d;
            rd_start_q <= rd_start_d;
            wr_cur_q   <= wr_cur_d;
            rdreq_q    <= rdreq_d;
            rdsel_q    <= rdsel_d;
            rdval_q    <= rdval_d;
            rddone_q   <= rddone_d;
            xfer_en_q  <= xfer_en_d;
            prdata_q   <= prdata_d;
            perr_q     <= perr_d;
        end
    end

    assign write_xfer_enable_o = xfer_en_q;
    assign read_done_flag_o    = rddone_q;

    // ==========================================================================
    // Arbiter; only the first write and read channels have hardware behind them
    logic [3:0] gnt;

    uda_arb u_arb (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .en_i     (arb_en_q),
        .mode_i   (arb_mode_q),
        .prio_i   ({prio_w1_q, prio_w0_q, prio_r1_q, prio_r0_q}),
        .req_i    ({1'b0, dma_req_i[MST_W0], 1'b0, dma_req_i[MST_R0]}),
        .gnt_o    (gnt)
    );

    assign dma_gnt_o = gnt;

    // ==========================================================================
    // Checks
    sequence s_arb_wr(logic en_bit);
        wr_acc && paddr_i == OFS_ARB && pwdata_i[ARB_EN_BIT] == en_bit;
    endsequence

    chk_fields_locked: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (arb_en_q and s_arb_wr(1'b1)) |=> $stable(arb_mode_q) && $stable(prio_r0_q))
        else $error("fields changed while arbiter enabled");
    chk_enable_refused: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_arb_wr(1'b1) and !prio_distinct(prio_w1_q, prio_w0_q, prio_r1_q, prio_r0_q))
        |=> arb_en_q == $past(arb_en_q)) else $error("enable taken with overlapping priorities");
    chk_rdreq_fetch: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rdreq_q && rdsel_q == RDSEL_WR_CUR |=> !rdreq_q && rddone_q && rdval_q == $past(wr_cur_q))
        else $error("indirect read did not complete");
    chk_cur_advance: assert property (@(posedge clk_i) disable iff (!resetn_i)
        xfer_en_q && wr_ep_move_i && !wr_acc |=> wr_cur_q == $past(wr_cur_q) + WORD_STEP)
        else $error("current address did not advance");
    chk_bus_aligned: assert property (@(posedge clk_i) disable iff (!resetn_i)
        xfer_en_q && wr_bus_move_i |=> wr_bus_q[1:0] == 2'h0) else $error("bus address unaligned");
    chk_xfer_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_xfer_done_i |=> !write_xfer_enable_o) else $error("transfer enable not cleared");
    chk_cur_hidden: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rd_acc && paddr_i == OFS_WR_CUR |=> prdata_o == 32'h00000000) else $error("current address leaked");
    chk_no_grant_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !arb_en_q ##1 !arb_en_q |-> dma_gnt_o == 4'h0) else $error("grant while disabled");

    sequence s_ind_req;
        wr_acc && paddr_i == OFS_RDREQ && pwdata_i[RDREQ_BIT];
    endsequence

    sequence s_ind_fetch;
        rdreq_q && rdsel_q == RDSEL_WR_CUR;
    endsequence

    chk_disable_taken: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_arb_wr(1'b0) |=> !arb_en_q)
        else $error("arbiter disable not taken");

    chk_enable_taken: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_arb_wr(1'b1) and prio_distinct(prio_w1_q, prio_w0_q, prio_r1_q, prio_r0_q)) |=> arb_en_q)
        else $error("enable refused with distinct priorities");

    chk_prio_frozen: assert property (@(posedge clk_i) disable iff (!resetn_i)
        arb_en_q |=> $stable(arb_mode_q) && $stable(prio_w1_q) && $stable(prio_w0_q)
                     && $stable(prio_r1_q) && $stable(prio_r0_q))
        else $error("arbiter fields moved while enabled");

    chk_start_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_acc && paddr_i == OFS_WR_START |=> wr_start_q == $past(pwdata_i))
        else $error("write start address not stored");

    chk_end_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_acc && paddr_i == OFS_WR_END |=> wr_end_q == $past(pwdata_i))
        else $error("write end address not stored");

    chk_read_start_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_acc && paddr_i == OFS_RD_START |=> rd_start_q == $past(pwdata_i))
        else $error("read start address not stored");

    chk_bus_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !(xfer_en_q && wr_bus_move_i) |=> $stable(wr_bus_q))
        else $error("bus address moved without delivery");

    chk_cur_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !xfer_en_q && !wr_acc |=> $stable(wr_cur_q))
        else $error("current address moved while idle");

    chk_xfer_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_acc && paddr_i == OFS_XFER_CTL && pwdata_i[XFER_EN_BIT] && !wr_xfer_done_i |=> write_xfer_enable_o)
        else $error("transfer enable not set");

    chk_ind_flow: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_ind_req and !rdreq_q && !pwdata_i[RDCLR_BIT]) ##1 s_ind_fetch |=> read_done_flag_o && !rdreq_q)
        else $error("indirect read sequence broken");

    chk_done_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rddone_q && !(wr_acc && paddr_i == OFS_RDREQ && pwdata_i[RDREQ_BIT]) |=> read_done_flag_o)
        else $error("done flag dropped on its own");

    chk_rdval_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !rdreq_q |=> $stable(rdval_q))
        else $error("read value moved without request");

    chk_err_decode: assert property (@(posedge clk_i) disable iff (!resetn_i)
        psel_i && !penable_i |=> pslverr_o == !$past(addr_mapped(paddr_i)))
        else $error("slave error does not match decode");

    chk_err_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !(psel_i && !penable_i) |=> !pslverr_o)
        else $error("slave error outside access phase");
endmodule : uda_top

// ===== sim/tb_usb_dma_arbiter_address_regs.sv
/*
 Self-checking bench for uda_top: APB read and write tasks, register sequences with expected values.
 Assumes uda_bus_target stands on the DMA side and answers the grants.
*/
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_usb_dma_arbiter_address_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import uda_pkg::*;
    // ==========================================================================
    // Signals
    logic        clk_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, bus_addr;
    logic        pready, pslverr, bus_move, xen, rdone, ep_move = 1'b0, xdone = 1'b0;
    logic [3:0]  req, gnt, want = 4'h0, first, seen;
    logic [7:0]  ofs [4] = '{8'h40, 8'h44, 8'h4c, 8'h50};
    logic [31:0] cfg [3] = '{32'h10000123, 32'h10003210, 32'h00003210};
    logic [3:0]  xf [3] = '{4'h4, 4'h1, 4'h0};
    logic [3:0]  xs [3] = '{4'h5, 4'h1, 4'h5};
    int          n_errors = 0, check_count = 0, cyc = 0;
    always #10 clk_i = ~clk_i;
    uda_top dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .wr_ep_move_i(ep_move), .wr_bus_move_i(bus_move), .wr_bus_addr_i(bus_addr),
        .wr_xfer_done_i(xdone), .dma_req_i(req), .dma_gnt_o(gnt), .write_xfer_enable_o(xen),
        .read_done_flag_o(rdone));
    uda_bus_target tgt_u (.clk_i(clk_i), .resetn_i(resetn_i), .want_i(want), .gnt_i(gnt),
        .base_i(32'h20000104), .byte_off_i(2'h3), .req_o(req), .move_o(bus_move), .addr_o(bus_addr));
    // ==========================================================================
    // Tasks
    task results();
        if (n_errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk_i);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK("register", x, r & m)
        `CHK("pslverr", xe, e)
    endtask : rd
    task ind(input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        wr(OFS_RDREQ, 32'h80000048);
        // Value is only trusted once the request flag has dropped
        for (int k = 0; k < 8; k++) begin
            apb(1'b0, OFS_RDREQ, 32'h0, r, e);
            if (r[31] === 1'b0) break;
        end
        `CHK("request", 1'b0, r[31])
        rd(OFS_RDVAL, 32'hffffffff, x, 1'b0);
        `CHK("done flag", 1'b1, rdone)
    endtask : ind
    task observe(input logic [3:0] w);
        first = 4'h0;
        seen  = 4'h0;
        @(posedge clk_i);
        want <= w;
        repeat (20) begin
            @(posedge clk_i);
            if (first === 4'h0) first = gnt;
            seen = seen | gnt;
        end
        want <= 4'h0;
        repeat (4) @(posedge clk_i);
    endtask : observe
    task pulse_ep();
        @(posedge clk_i);
        ep_move <= 1'b1;
        @(posedge clk_i);
        ep_move <= 1'b0;
    endtask : pulse_ep
    // ==========================================================================
    // Timeout
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    // ==========================================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(OFS_ARB, 32'h90003333, 32'h80003210, 1'b0);
        for (int i = 0; i < 4; i++) rd(ofs[i], 32'hffffffff, 32'h0fffffff, 1'b0);
        rd(OFS_WR_CUR, 32'hffffffff, 32'h0, 1'b0);
        rd(8'h60, 32'h0, 32'h0, 1'b1);
        ind(32'h0);
        for (int i = 0; i < 4; i++) wr(ofs[i], 32'ha5c30f10 + i);
        for (int i = 0; i < 4; i++) rd(ofs[i], 32'hffffffff, (i == 2) ? 32'h0fffffff : 32'ha5c30f10 + i, 1'b0);
        wr(OFS_WR_START, 32'h10000000);
        wr(OFS_XFER_CTL, 32'h1);
        @(posedge clk_i);
        `CHK("xfer enable", 1'b1, xen)
        repeat (3) pulse_ep();
        ind(32'h1000000c);
        @(posedge clk_i);
        xdone <= 1'b1;
        @(posedge clk_i);
        xdone <= 1'b0;
        @(posedge clk_i);
        `CHK("xfer enable", 1'b0, xen)
        pulse_ep();
        ind(32'h1000000c);
        // Field writes while enabled must not land; disabling keeps the old fields
        wr(OFS_ARB, 32'h90000123);
        rd(OFS_ARB, 32'h90003333, 32'h80003210, 1'b0);
        wr(OFS_ARB, 32'h00000000);
        rd(OFS_ARB, 32'h90003333, 32'h00003210, 1'b0);
        observe(4'h5);
        `CHK("grant", 4'h0, seen)
        wr(OFS_ARB, 32'h10000113);
        wr(OFS_ARB, 32'h90000113);
        rd(OFS_ARB, 32'h90003333, 32'h10000113, 1'b0);
        // Bus deliveries only count while a transfer is enabled
        wr(OFS_XFER_CTL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_ARB, cfg[i]);
            wr(OFS_ARB, cfg[i] | 32'h80000000);
            rd(OFS_ARB, 32'h90003333, cfg[i] | 32'h80000000, 1'b0);
            observe(4'h5);
            if (i < 2) `CHK("first grant", xf[i], first)
            `CHK("grants seen", xs[i], seen)
            wr(OFS_ARB, 32'h00000000);
        end
        rd(OFS_WR_BUS, 32'hffffffff, 32'h20000104, 1'b0);
        results();
    end
endmodule : tb_usb_dma_arbiter_address_regs

// ===== sim/uda_bus_target.sv
/*
 Bus target model for the write and read DMA masters of uda_top.
 Assumes requests are wanted by the bench and grants come back on clk_i.
*/
module uda_bus_target (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [3:0]  want_i,
    input  wire logic [3:0]  gnt_i,
    input  wire logic [31:0] base_i,
    input  wire logic [1:0]  byte_off_i,
    output logic      [3:0]  req_o,
    output logic             move_o,
    output logic      [31:0] addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================================
    // Write master asks once per want, read master keeps asking
    logic taken_q;
    assign req_o = {want_i[3], want_i[2] & ~taken_q, want_i[1:0]};
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            taken_q <= 1'b0;
            move_o  <= 1'b0;
            addr_o  <= 32'h00000000;
        end else begin
            taken_q <= want_i[2] & (taken_q | gnt_i[2]);
            move_o  <= gnt_i[2] & ~taken_q;
            // Byte-wide delivery; released address toggles so stale values never pass
            addr_o  <= (gnt_i[2] & ~taken_q) ? base_i + 32'(byte_off_i) : ~addr_o;
        end
    end
endmodule : uda_bus_target
